// [bench/ccd_sink_model.sv]
// Far-side model: a clock input that measures the widths it receives
`timescale 1ns/1ns

module ccd_sink_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_in,
  output int low_w,
  output int high_w,
  output int edges
);
  int run;
  logic last;

  // Widths are only valid once two edges have passed after a change
  always @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1;
      last <= 1'b0;
      edges <= 0;
      low_w <= 0;
      high_w <= 0;
    end else if (clk_in !== last) begin
      if (last) high_w <= run;
      else low_w <= run;
      run <= 1;
      last <= clk_in;
      edges <= edges + 1;
    end else begin
      run <= run + 1;
    end
  end
endmodule

// [bench/lvds_cmos_channel_divider_tb.sv]
// Self-checking bench for the channel divider block
`timescale 1ns/1ns
`include "ccd_defs.svh"

module lvds_cmos_channel_divider_tb;
  import ccd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sync_n = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, chan3, chan4, dcc_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int n_tests = 0;
  int lw3, hw3, e3, lw4, hw4, e4, l1, h1, l2, h2, p1, t0, t5, t;
  int mdl[int];
  byte unsigned mk[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h01, 8'hFF};

  always #5 aclk = ~aclk;

  ccd_channel #(.ADDR_W(12)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync_n(sync_n),
    .chan3_out_q(chan3), .chan4_out(chan4), .duty_correction_en(dcc_en)
  );
  ccd_sink_model u_s3 (.aclk(aclk), .aresetn(aresetn), .clk_in(chan3),
    .low_w(lw3), .high_w(hw3), .edges(e3));
  ccd_sink_model u_s4 (.aclk(aclk), .aresetn(aresetn), .clk_in(chan4),
    .low_w(lw4), .high_w(hw4), .edges(e4));

  // ---------------------------------------------------------------
  // Compare, bus and wait tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got,
               exp);
    end
  endtask

  task automatic chk_lvl(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: level %s got %b", $time, what, got);
    end
  endtask

  function automatic logic [1:0] resp_of(input logic [9:0] idx);
    return mdl.exists(idx) ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
  endfunction

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    if (bvalid !== 1'b1) chk(n, 0, "write wait");
    chk(bresp, resp_of(idx), "bresp");
    if (mdl.exists(idx)) mdl[idx] = d & mk[idx - 10'h199];
  endtask

  task automatic rd(input logic [9:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    if (rvalid !== 1'b1) chk(n, 0, "read wait");
    chk(rresp, resp_of(idx), "rresp");
    chk(rdata, mdl.exists(idx) ? mdl[idx] : 0, "rdata");
  endtask

  // Six edges on both outputs leave stable widths in the sinks
  task automatic settle();
    int a, b, n;
    a = e3;
    b = e4;
    n = 0;
    while ((e3 < a + 6 || e4 < b + 6) && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 5000) chk(n, 0, "edge wait");
  endtask

  task automatic sync_run(output int tt, input logic lvl);
    @(posedge aclk);
    sync_n <= 1'b0;
    repeat (12) @(posedge aclk);
    chk_lvl(chan3, lvl, "sync held");
    // Held stages sit at start level: hold flag, stage two and output
    mdl[`CCD_IDX_STATUS] = lvl ? 8'h15 : 8'h10;
    rd(`CCD_IDX_STATUS);
    mdl.delete(`CCD_IDX_STATUS);
    sync_n <= 1'b1;
    tt = 0;
    while (chan3 === lvl && tt < 200) begin
      @(posedge aclk);
      tt++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(11));
    for (int i = 0; i < 6; i++) mdl[10'h199 + i] = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(10'h199 + i);
    chk_lvl(dcc_en, 1'b1, "dcc reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(10'h199 + i, 8'($urandom_range(255, 0)));
      rd(10'h199 + i);
    end
    wr(10'h1A5, 8'h5A);
    rd(10'h1A5);
    rd(10'h198);
    wr(`CCD_IDX_C3_DCC, 8'h01);
    chk_lvl(dcc_en, 1'b0, "dcc off");
    wr(`CCD_IDX_C3_DCC, 8'h00);
    chk_lvl(dcc_en, 1'b1, "dcc on");
    wr(`CCD_IDX_C3_PHASE, 8'h00);
    $display("test registers done");
    // Edge cases first: all-low-short then all-high-short
    for (int k = 0; k < 4; k++) begin
      l1 = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(15, 0);
      h1 = (k == 0) ? 15 : (k == 1) ? 0 : $urandom_range(15, 0);
      l2 = $urandom_range(3, 0);
      h2 = $urandom_range(3, 0);
      p1 = l1 + h1 + 2;
      wr(`CCD_IDX_C3_S1_CNT, {l1[3:0], h1[3:0]});
      wr(`CCD_IDX_C4_S1_CNT, {h1[3:0], l1[3:0]});
      wr(`CCD_IDX_C3_S2_CNT, {l2[3:0], h2[3:0]});
      wr(`CCD_IDX_C3_CTRL, 8'h20);
      settle();
      chk(lw3, l1 + 1, "c3 s1 low");
      chk(hw3, h1 + 1, "c3 s1 high");
      chk(lw4, h1 + 1, "c4 low");
      chk(hw4, l1 + 1, "c4 high");
      wr(`CCD_IDX_C3_CTRL, 8'h10);
      settle();
      chk(lw3, l2 + 1, "c3 s2 low");
      chk(hw3, h2 + 1, "c3 s2 high");
      wr(`CCD_IDX_C3_CTRL, 8'h00);
      settle();
      chk(lw3, (l2 + 1) * p1, "cascade low");
      chk(hw3, (h2 + 1) * p1, "cascade high");
    end
    $display("test dividers done");
    // Stage one bypassed so stage two phase counts whole cycles
    wr(`CCD_IDX_C3_S2_CNT, 8'h23);
    wr(`CCD_IDX_C3_CTRL, 8'h10);
    sync_run(t0, 1'b0);
    wr(`CCD_IDX_C3_PHASE, 8'h50);
    sync_run(t5, 1'b0);
    chk(t5 - t0, 5, "phase shift");
    wr(`CCD_IDX_C3_CTRL, 8'h12);
    sync_run(t, 1'b1);
    chk(t, t5 + 1, "start high run");
    $display("test sync done");
    wr(`CCD_IDX_C3_CTRL, 8'h0C);
    @(posedge aclk);
    sync_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk_lvl(chan3, 1'b1, "force high");
    wr(`CCD_IDX_C3_CTRL, 8'h08);
    repeat (3) @(posedge aclk);
    chk_lvl(chan3, 1'b0, "force low");
    sync_n <= 1'b1;
    $display("test force done");
    report_and_stop();
  end
endmodule

// [logic/ccd_channel.sv]
// Channel 3 two-stage divider and channel 4 first stage, AXI4-Lite regs
//
// Function
// - Ch3 stage one low time is field+1
// - Ch3 stage one high time is field+1
// - Zero count means one cycle; counts reset zero
// - Ch3 stage two uses own count register
// - Stage two bypass passes its input through
// - Stage one bypass passes its input through
// - Ignore-sync bit makes Ch3 dividers disregard sync
// - Force bit sets output level while sync held, needs ignore-sync
// - Stage two start level bit
// - Stage one start level bit
// - Duty correction on unless disable bit set
// - Ch4 stage one low time is field+1
// - Ch4 stage one high time is field+1
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "ccd_defs.svh"

module ccd_channel
  import ccd_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_n,
  output logic chan3_out_q,
  output logic chan4_out,
  output logic duty_correction_en
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  ccd_byte_t c3_s1_q;
  ccd_byte_t c3_ph_q;
  ccd_byte_t c3_s2_q;
  logic [5:0] c3_ctl_q;
  logic c3_dcc_off_q;
  ccd_byte_t c4_s1_q;

  logic aw_held_q;
  logic [9:0] aw_idx_q;
  logic w_held_q;
  ccd_byte_t w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic [`CCD_SYNC_FFS-1:0] sync_ff_q;
  logic sync_lvl_q;
  logic sync_act;
  logic nosync;
  logic hold3;
  logic s1_out;
  logic s1_rise;
  logic s2_out;
  logic c4_out;
  logic do_write;
  logic [9:0] ar_idx;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  assign nosync = c3_ctl_q[`CCD_CTRL_NOSYNC];

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    case (aw_idx_q)
      `CCD_IDX_C3_S1_CNT: wr_ok = 1'b1;
      `CCD_IDX_C3_PHASE: wr_ok = 1'b1;
      `CCD_IDX_C3_S2_CNT: wr_ok = 1'b1;
      `CCD_IDX_C3_CTRL: wr_ok = 1'b1;
      `CCD_IDX_C3_DCC: wr_ok = 1'b1;
      `CCD_IDX_C4_S1_CNT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 10'h000;
      w_held_q <= 1'b0;
      w_data_q <= `CCD_RST_BYTE;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CCD_RESP_OKAY;
    end else begin
      // Address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries data; other lanes are read-as-zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c3_s1_q <= `CCD_RST_BYTE;
      c3_ph_q <= `CCD_RST_BYTE;
      c3_s2_q <= `CCD_RST_BYTE;
      c3_ctl_q <= 6'h00;
      c3_dcc_off_q <= 1'b0;
      c4_s1_q <= `CCD_RST_BYTE;
    end else if (do_write && w_lane_q) begin
      case (aw_idx_q)
        `CCD_IDX_C3_S1_CNT: c3_s1_q <= w_data_q;
        `CCD_IDX_C3_PHASE: c3_ph_q <= w_data_q;
        `CCD_IDX_C3_S2_CNT: c3_s2_q <= w_data_q;
        `CCD_IDX_C3_CTRL: c3_ctl_q <= w_data_q[5:0];
        `CCD_IDX_C3_DCC: c3_dcc_off_q <= w_data_q[`CCD_DCC_OFF_BIT];
        `CCD_IDX_C4_S1_CNT: c4_s1_q <= w_data_q;
        default: c3_ctl_q <= c3_ctl_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign ar_idx = s_axi_araddr[11:2];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ar_idx)
      `CCD_IDX_C3_S1_CNT: rd_word[7:0] = c3_s1_q;
      `CCD_IDX_C3_PHASE: rd_word[7:0] = c3_ph_q;
      `CCD_IDX_C3_S2_CNT: rd_word[7:0] = c3_s2_q;
      `CCD_IDX_C3_CTRL: rd_word[5:0] = c3_ctl_q;
      `CCD_IDX_C3_DCC: rd_word[0] = c3_dcc_off_q;
      `CCD_IDX_C4_S1_CNT: rd_word[7:0] = c4_s1_q;
      `CCD_IDX_STATUS: rd_word[4:0] = {hold3, c4_out, s2_out, s1_out,
                                        chan3_out_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Chip-level sync pin
  // ---------------------------------------------------------------
  // Level counts only once the second and third flops agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ff_q <= 3'h7;
      sync_lvl_q <= 1'b1;
    end else begin
      sync_ff_q <= {sync_ff_q[1:0], sync_n};
      if (sync_ff_q[1] == sync_ff_q[2]) begin
        sync_lvl_q <= sync_ff_q[2];
      end
    end
  end

  assign sync_act = !sync_lvl_q;
  assign hold3 = sync_act && !nosync;

  // ---------------------------------------------------------------
  // Divider stages
  // ---------------------------------------------------------------
  ccd_stage u_c3_s1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(1'b1),
    .low_cnt(c3_s1_q[`CCD_LOW_MSB:`CCD_LOW_LSB]),
    .high_cnt(c3_s1_q[`CCD_HIGH_MSB:`CCD_HIGH_LSB]),
    .phase(c3_ph_q[3:0]),
    .bypass(c3_ctl_q[`CCD_CTRL_BYP1]),
    .start_high(c3_ctl_q[`CCD_CTRL_START1]),
    .hold(hold3),
    .out_q(s1_out),
    .rise_q(s1_rise)
  );

  // Stage two advances once per stage one output period
  ccd_stage u_c3_s2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(s1_rise),
    .low_cnt(c3_s2_q[`CCD_LOW_MSB:`CCD_LOW_LSB]),
    .high_cnt(c3_s2_q[`CCD_HIGH_MSB:`CCD_HIGH_LSB]),
    .phase(c3_ph_q[7:4]),
    .bypass(c3_ctl_q[`CCD_CTRL_BYP2]),
    .start_high(c3_ctl_q[`CCD_CTRL_START2]),
    .hold(hold3),
    .out_q(s2_out),
    .rise_q()
  );

  // Channel 4 has only its counts; phase, bypass and start level are tied low
  ccd_stage u_c4_s1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(1'b1),
    .low_cnt(c4_s1_q[`CCD_LOW_MSB:`CCD_LOW_LSB]),
    .high_cnt(c4_s1_q[`CCD_HIGH_MSB:`CCD_HIGH_LSB]),
    .phase(4'h0),
    .bypass(1'b0),
    .start_high(1'b0),
    .hold(sync_act),
    .out_q(c4_out),
    .rise_q()
  );

  assign chan4_out = c4_out;
  assign duty_correction_en = !c3_dcc_off_q;

  // ---------------------------------------------------------------
  // Channel 3 output and forced level
  // ---------------------------------------------------------------
  // Force applies only while sync is held and ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan3_out_q <= 1'b0;
    end else if (nosync && sync_act) begin
      chan3_out_q <= c3_ctl_q[`CCD_CTRL_FORCE];
    end else if (c3_ctl_q[`CCD_CTRL_BYP2]) begin
      // Stage two ticks are pulses, so bypass routes the stage one clock
      chan3_out_q <= s1_out;
    end else begin
      chan3_out_q <= s2_out;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_force_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (nosync && sync_act) |=> chan3_out_q == $past(c3_ctl_q[2]))
    else $error("forced level not on channel 3 output");

  a_ignore_sync: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_act |-> (hold3 == !nosync))
    else $error("sync hold disagrees with ignore bit");

  a_counts_reset: assert property (
    @(posedge aclk)
    !aresetn |=> (c3_s1_q == 8'h00 && c3_s2_q == 8'h00 &&
                  c4_s1_q == 8'h00 && c3_ph_q == 8'h00))
    else $error("count fields not zero after reset");

  a_stage2_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && w_lane_q && aw_idx_q == 10'h19B)
    |=> c3_s2_q == $past(w_data_q))
    else $error("stage two counts not written");

  a_dcc_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && w_lane_q && aw_idx_q == 10'h19D)
    |=> duty_correction_en == !$past(w_data_q[0]))
    else $error("duty correction does not follow its bit");

  a_write_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid ##0 (s_axi_bresp == `CCD_RESP_SLVERR)
      == !$past(wr_ok))
    else $error("write response missing or wrong");

endmodule

// [logic/ccd_defs.svh]
// Register indexes, field positions, reset values and timing counts
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// ---------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define CCD_IDX_C3_S1_CNT 10'h199
`define CCD_IDX_C3_PHASE 10'h19A
`define CCD_IDX_C3_S2_CNT 10'h19B
`define CCD_IDX_C3_CTRL 10'h19C
`define CCD_IDX_C3_DCC 10'h19D
`define CCD_IDX_C4_S1_CNT 10'h19E
`define CCD_IDX_STATUS 10'h1A4

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CCD_LOW_MSB 7
`define CCD_LOW_LSB 4
`define CCD_HIGH_MSB 3
`define CCD_HIGH_LSB 0
`define CCD_CTRL_BYP2 5
`define CCD_CTRL_BYP1 4
`define CCD_CTRL_NOSYNC 3
`define CCD_CTRL_FORCE 2
`define CCD_CTRL_START2 1
`define CCD_CTRL_START1 0
`define CCD_DCC_OFF_BIT 0

// ---------------------------------------------------------------
// Reset values and bus constants
// ---------------------------------------------------------------
`define CCD_RST_BYTE 8'h00
`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2
`define CCD_SYNC_FFS 3

`endif

// [logic/ccd_pkg.sv]
// Types shared by the channel divider modules
package ccd_pkg;

  typedef enum logic [1:0] {
    CCD_ST_HOLD = 2'b00,
    CCD_ST_PHASE = 2'b01,
    CCD_ST_RUN = 2'b10
  } ccd_state_e;

  typedef logic [3:0] ccd_nib_t;
  typedef logic [7:0] ccd_byte_t;

endpackage

// [logic/ccd_stage.sv]
// One divider stage: low/high counts, phase offset, bypass, start level
`timescale 1ns/1ns
`include "ccd_defs.svh"

module ccd_stage
  import ccd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_tick,
  input wire ccd_nib_t low_cnt,
  input wire ccd_nib_t high_cnt,
  input wire ccd_nib_t phase,
  input wire logic bypass,
  input wire logic start_high,
  input wire logic hold,
  output logic out_q,
  output logic rise_q
);

  ccd_state_e state_q;
  ccd_nib_t cnt_q;
  ccd_nib_t ph_cnt_q;
  ccd_nib_t limit;

  assign limit = out_q ? high_cnt : low_cnt;

  // ---------------------------------------------------------------
  // Divider sequence
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CCD_ST_HOLD;
      cnt_q <= 4'h0;
      ph_cnt_q <= 4'h0;
      out_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (hold) begin
        state_q <= CCD_ST_HOLD;
        cnt_q <= 4'h0;
        out_q <= start_high;
      end else if (bypass) begin
        // Counters idle; the input tick passes straight through
        out_q <= in_tick;
        rise_q <= in_tick;
      end else begin
        case (state_q)
          CCD_ST_HOLD: begin
            cnt_q <= 4'h0;
            out_q <= start_high;
            if (phase == 4'h0) begin
              state_q <= CCD_ST_RUN;
            end else begin
              ph_cnt_q <= phase - 4'h1;
              state_q <= CCD_ST_PHASE;
            end
          end
          CCD_ST_PHASE: begin
            if (in_tick) begin
              if (ph_cnt_q == 4'h0) begin
                state_q <= CCD_ST_RUN;
              end else begin
                ph_cnt_q <= ph_cnt_q - 4'h1;
              end
            end
          end
          CCD_ST_RUN: begin
            if (in_tick) begin
              if (cnt_q == limit) begin
                // Level lasts limit+1 input cycles, so zero means one
                out_q <= ~out_q;
                rise_q <= ~out_q;
                cnt_q <= 4'h0;
              end else begin
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          default: begin
            state_q <= CCD_ST_HOLD;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_low_ends: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == CCD_ST_RUN && !hold && !bypass && in_tick && !out_q &&
     cnt_q == low_cnt) |=> out_q)
    else $error("low phase did not end after low count");

  a_high_ends: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == CCD_ST_RUN && !hold && !bypass && in_tick && out_q &&
     cnt_q == high_cnt) |=> !out_q)
    else $error("high phase did not end after high count");

  a_no_early: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == CCD_ST_RUN && !hold && !bypass && cnt_q != limit)
    |=> out_q == $past(out_q))
    else $error("level changed before its count ran out");

  a_bypass_pass: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bypass && !hold) |=> (out_q == $past(in_tick)))
    else $error("bypassed stage did not pass its input");

  a_hold_start: assert property (
    @(posedge aclk) disable iff (!aresetn)
    hold |=> (out_q == $past(start_high) && state_q == CCD_ST_HOLD))
    else $error("held stage not at its start level");

  a_phase_delay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == CCD_ST_PHASE && !hold && !bypass)
    |=> out_q == $past(out_q))
    else $error("output moved during phase delay");

endmodule
